// ===== hdl/upio_map.vh
// register map, field positions, codes and timing constants of the interrupt output block
//
// Behaviour
// - software sets the interrupt pin polarity and its level or pulse style through two bits of the configuration register at 10h.
// - after reset the pin is active low and in level style.
// - in pulse style one pulse of at least 60 ns is sent each time the OR of the enabled status bits rises from zero to one while no pulse is running.
// - the global gate bit of the mode register at 0Ch decides whether the pin may assert at all.
// - each USB event sets its own bit of the USB status register and each DMA event its own bit of the DMA reason register.
// - a status bit counts towards the pin only while its bit in the matching enable register is set.
// - a two-bit control-pipe field of the configuration register picks which control endpoint outcomes raise an event.
// - a two-bit IN-pipe field of the configuration register picks which IN endpoint outcomes raise an event.
// - a two-bit OUT-pipe field of the configuration register picks which OUT endpoint outcomes raise an event.
// - with the gate cleared events still set status bits, and setting the gate later asserts the pin if a bit is already set.
// - in level style, clearing the gate does not by itself release a pin that is already asserted.
// - the pin releases once the enabled status bits are all cleared, and a clear only acts when every byte of the register is written.
`ifndef UPIO_MAP_VH
`define UPIO_MAP_VH

// register port widths
`define UPIO_AW            8
`define UPIO_DW            16
`define UPIO_CFG_W         8

// register offsets
`define UPIO_OFS_MODE      8'h0c
`define UPIO_OFS_ICFG      8'h10
`define UPIO_OFS_USB_EN    8'h14
`define UPIO_OFS_USB_ST    8'h18
`define UPIO_OFS_DMA_ST    8'h50
`define UPIO_OFS_DMA_EN    8'h54

// reset values
`define UPIO_MODE_RST      16'h0000
`define UPIO_CFG_RST       8'h00
`define UPIO_EN_RST        16'h0000
`define UPIO_ST_RST        16'h0000
`define UPIO_RD_NONE       16'h0000
`define UPIO_CFG_PAD       8'h00

// field positions
`define UPIO_MODE_GATE     3
`define UPIO_CFG_STYLE     0
`define UPIO_CFG_POL       1
`define UPIO_CFG_OUT_LO    2
`define UPIO_CFG_IN_LO     4
`define UPIO_CFG_CTRL_LO   6
`define UPIO_BIT_CTRL      0
`define UPIO_BIT_IN        1
`define UPIO_BIT_OUT       2
`define UPIO_PIPE_BITS     3

// pipe select codes
`define UPIO_SEL_BOTH      2'b00
`define UPIO_SEL_ACK       2'b01
`define UPIO_SEL_NAK       2'b10
`define UPIO_SEL_NONE      2'b11

// byte lanes all written
`define UPIO_BE_ALL        2'b11

// timing
`define UPIO_PULSE_NS      60
`define UPIO_CLK_NS        50

`endif

// ===== hdl/upio_pulse_gen.v
// fixed-length pulse stretcher for the interrupt pin
`timescale 1ns/1ps
module upio_pulse_gen #(
    parameter CW     = 4,
    parameter CYCLES = 2
) (
    input  wire          ref_clk,
    input  wire          nrst,
    input  wire          trig,
    output wire          busy
);

    localparam [CW-1:0] LOAD = CYCLES;
    localparam [CW-1:0] ZERO = {CW{1'b0}};
    localparam [CW-1:0] ONE  = {{(CW-1){1'b0}}, 1'b1};

    reg  [CW-1:0] cnt_ff;
    reg  [CW-1:0] nxt_cnt;

    // retrigger during a pulse is ignored so width never stretches unevenly
    always @* begin
        nxt_cnt = cnt_ff;
        if (cnt_ff != ZERO) begin
            nxt_cnt = cnt_ff - ONE;
        end else if (trig) begin
            nxt_cnt = LOAD;
        end
    end

    // down counter
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff <= ZERO;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign busy = (cnt_ff != ZERO);

endmodule

// ===== hdl/upio_irq_ctrl.v
// interrupt status, enable, gating and pin drive of the usb peripheral
`timescale 1ns/1ps
`include "upio_map.vh"
module upio_irq_ctrl #(
    parameter PCW = 4
) (
    input  wire                  ref_clk,
    input  wire                  nrst,
    input  wire [`UPIO_AW-1:0]   reg_addr,
    input  wire [`UPIO_DW-1:0]   reg_wdata,
    input  wire [1:0]            reg_be,
    input  wire                  reg_wr,
    input  wire                  reg_rd,
    output wire [`UPIO_DW-1:0]   reg_rdata,
    input  wire [`UPIO_DW-1:0]   usb_evt,
    input  wire [`UPIO_DW-1:0]   dma_evt,
    input  wire                  ctrl_ack,
    input  wire                  ctrl_nak,
    input  wire                  in_ack,
    input  wire                  in_nak,
    input  wire                  out_ack,
    input  wire                  out_nak,
    output wire                  irq_pin
);

    ////////////////////////////////////////////////////////////////////////
    // constants

    // least time rounds up to whole cycles, never below one
    localparam PULSE_RAW = (`UPIO_PULSE_NS + `UPIO_CLK_NS - 1) / `UPIO_CLK_NS;
    localparam PULSE_CYC = (PULSE_RAW < 1) ? 1 : PULSE_RAW;
    localparam DW        = `UPIO_DW;
    localparam PB        = `UPIO_PIPE_BITS;

    ////////////////////////////////////////////////////////////////////////
    // functions

    // merge write data into a register lane by lane
    function [DW-1:0] lane_merge;
        input [DW-1:0] old_val;
        input [DW-1:0] new_val;
        input [1:0]    be;
        begin
            lane_merge[7:0]  = be[0] ? new_val[7:0]  : old_val[7:0];
            lane_merge[15:8] = be[1] ? new_val[15:8] : old_val[15:8];
        end
    endfunction

    // qualify one pipe outcome with its select field
    function pipe_qual;
        input [1:0] sel;
        input       ack;
        input       nak;
        begin
            case (sel)
                `UPIO_SEL_BOTH: pipe_qual = ack | nak;
                `UPIO_SEL_ACK:  pipe_qual = ack;
                `UPIO_SEL_NAK:  pipe_qual = nak;
                `UPIO_SEL_NONE: pipe_qual = 1'b0;
                default:        pipe_qual = 1'b0;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // registers

    reg  [DW-1:0]          mode_ff;
    reg  [`UPIO_CFG_W-1:0] cfg_ff;
    reg  [DW-1:0]          usb_en_ff;
    reg  [DW-1:0]          dma_en_ff;
    reg  [DW-1:0]          usb_st_ff;
    reg  [DW-1:0]          dma_st_ff;
    reg  [DW-1:0]          rdata_ff;
    reg                    level_ff;
    reg                    gated_d_ff;
    reg                    irq_pin_ff;

    reg  [DW-1:0]          nxt_rdata;
    wire [DW-1:0]          nxt_usb_st;
    wire [DW-1:0]          nxt_dma_st;
    reg                    nxt_level;
    wire                   nxt_irq_pin;

    ////////////////////////////////////////////////////////////////////////
    // address decode

    wire wr_mode   = reg_wr & (reg_addr == `UPIO_OFS_MODE);
    wire wr_cfg    = reg_wr & (reg_addr == `UPIO_OFS_ICFG);
    wire wr_usb_en = reg_wr & (reg_addr == `UPIO_OFS_USB_EN);
    wire wr_dma_en = reg_wr & (reg_addr == `UPIO_OFS_DMA_EN);
    wire full_wr   = (reg_be == `UPIO_BE_ALL);

    // partial writes never clear: a half clear would leave stale bits
    wire clr_usb   = reg_wr & full_wr & (reg_addr == `UPIO_OFS_USB_ST);
    wire clr_dma   = reg_wr & full_wr & (reg_addr == `UPIO_OFS_DMA_ST);

    ////////////////////////////////////////////////////////////////////////
    // configuration fields

    wire       gate      = mode_ff[`UPIO_MODE_GATE];
    wire       style_lvl = ~cfg_ff[`UPIO_CFG_STYLE];
    wire       pol_high  = cfg_ff[`UPIO_CFG_POL];
    wire [1:0] ctrl_sel  = cfg_ff[`UPIO_CFG_CTRL_LO +: 2];
    wire [1:0] in_sel    = cfg_ff[`UPIO_CFG_IN_LO +: 2];
    wire [1:0] out_sel   = cfg_ff[`UPIO_CFG_OUT_LO +: 2];

    ////////////////////////////////////////////////////////////////////////
    // pipe event selection

    wire ctrl_hit = pipe_qual(ctrl_sel, ctrl_ack, ctrl_nak);
    wire in_hit   = pipe_qual(in_sel, in_ack, in_nak);
    wire out_hit  = pipe_qual(out_sel, out_ack, out_nak);

    // pipe outcomes land in the low bits next to ordinary usb events
    wire [PB-1:0] pipe_vec;
    assign pipe_vec[`UPIO_BIT_CTRL] = ctrl_hit;
    assign pipe_vec[`UPIO_BIT_IN]   = in_hit;
    assign pipe_vec[`UPIO_BIT_OUT]  = out_hit;

    wire [DW-1:0] usb_set = usb_evt | {{(DW-PB){1'b0}}, pipe_vec};

    ////////////////////////////////////////////////////////////////////////
    // sticky status bits

    // set wins over clear so an event in the clearing cycle survives
    genvar gi;
    generate
        for (gi = 0; gi < DW; gi = gi + 1) begin : g_st
            assign nxt_usb_st[gi] = usb_set[gi] |
                                    (usb_st_ff[gi] & ~(clr_usb & reg_wdata[gi]));
            assign nxt_dma_st[gi] = dma_evt[gi] |
                                    (dma_st_ff[gi] & ~(clr_dma & reg_wdata[gi]));
        end
    endgenerate

    // status registers take events regardless of the gate
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            usb_st_ff <= `UPIO_ST_RST;
            dma_st_ff <= `UPIO_ST_RST;
        end else begin
            usb_st_ff <= nxt_usb_st;
            dma_st_ff <= nxt_dma_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers

    // mode, configuration and enables, written lane by lane
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mode_ff   <= `UPIO_MODE_RST;
            cfg_ff    <= `UPIO_CFG_RST;
            usb_en_ff <= `UPIO_EN_RST;
            dma_en_ff <= `UPIO_EN_RST;
        end else begin
            if (wr_mode) begin
                mode_ff <= lane_merge(mode_ff, reg_wdata, reg_be);
            end
            if (wr_cfg && reg_be[0]) begin
                cfg_ff <= reg_wdata[`UPIO_CFG_W-1:0];
            end
            if (wr_usb_en) begin
                usb_en_ff <= lane_merge(usb_en_ff, reg_wdata, reg_be);
            end
            if (wr_dma_en) begin
                dma_en_ff <= lane_merge(dma_en_ff, reg_wdata, reg_be);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path

    // unmapped offsets read zero, config sits in the low byte
    always @* begin
        case (reg_addr)
            `UPIO_OFS_MODE:   nxt_rdata = mode_ff;
            `UPIO_OFS_ICFG:   nxt_rdata = {`UPIO_CFG_PAD, cfg_ff};
            `UPIO_OFS_USB_EN: nxt_rdata = usb_en_ff;
            `UPIO_OFS_USB_ST: nxt_rdata = usb_st_ff;
            `UPIO_OFS_DMA_ST: nxt_rdata = dma_st_ff;
            `UPIO_OFS_DMA_EN: nxt_rdata = dma_en_ff;
            default:          nxt_rdata = `UPIO_RD_NONE;
        endcase
    end

    // read data held until the next read
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_ff <= `UPIO_RD_NONE;
        end else if (reg_rd) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // pending and gating

    wire usb_pend = |(usb_st_ff & usb_en_ff);
    wire dma_pend = |(dma_st_ff & dma_en_ff);
    wire any_pend = usb_pend | dma_pend;
    wire gated    = any_pend & gate;

    // level: gate only arms assertion, release follows status alone
    always @* begin
        nxt_level = level_ff;
        if (!any_pend) begin
            nxt_level = 1'b0;
        end else if (gate) begin
            nxt_level = 1'b1;
        end
    end

    // level latch and pulse edge detector
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            level_ff   <= 1'b0;
            gated_d_ff <= 1'b0;
        end else begin
            level_ff   <= nxt_level;
            gated_d_ff <= gated;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pulse timing

    // gate rising with bits already set counts as a new rise
    wire pulse_trig = gated & ~gated_d_ff & ~style_lvl;
    wire pulse_busy;

    upio_pulse_gen #(
        .CW     (PCW),
        .CYCLES (PULSE_CYC)
    ) u_pulse (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .trig    (pulse_trig),
        .busy    (pulse_busy)
    );

    ////////////////////////////////////////////////////////////////////////
    // pin drive

    // registered so the pin never glitches on decode
    wire active = style_lvl ? level_ff : pulse_busy;
    assign nxt_irq_pin = pol_high ? active : ~active;

    // idle level is high because reset selects active low
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq_pin_ff <= 1'b1;
        end else begin
            irq_pin_ff <= nxt_irq_pin;
        end
    end

    assign irq_pin = irq_pin_ff;

endmodule

// ===== sim/upio_irq_checker.sv
// concurrent checks on the ports of the interrupt output block
`timescale 1ns/1ps
module upio_irq_checker #(
    parameter PCW = 4
) (
    input wire        ref_clk,
    input wire        nrst,
    input wire [7:0]  reg_addr,
    input wire [15:0] reg_wdata,
    input wire [1:0]  reg_be,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [15:0] reg_rdata,
    input wire [15:0] usb_evt,
    input wire [15:0] dma_evt,
    input wire        ctrl_ack,
    input wire        ctrl_nak,
    input wire        in_ack,
    input wire        in_nak,
    input wire        out_ack,
    input wire        out_nak,
    input wire        irq_pin
);
    reg  [7:0]  cfg_ff;
    reg  [1:0]  cfg_age_ff;
    reg         gate_ff;
    reg  [15:0] uen_ff;
    wire        act    = (irq_pin == cfg_ff[1]);
    wire        old    = (cfg_age_ff == 2'h3);
    // besides a config write, status clears and enable writes are the only ways software can release the pin
    wire        clr_wr = reg_wr && (reg_addr == 8'h18 || reg_addr == 8'h50 ||
                                    reg_addr == 8'h14 || reg_addr == 8'h54);
    // shadow of the programming registers; age hides polarity flips in flight
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_ff <= 8'h00;
            cfg_age_ff <= 2'h3;
            gate_ff <= 1'b0;
            uen_ff <= 16'h0000;
        end else begin
            cfg_age_ff <= (reg_wr && reg_addr == 8'h10) ? 2'h0 : cfg_age_ff + {1'b0, !old};
            if (reg_wr && reg_be[0] && reg_addr == 8'h10) cfg_ff <= reg_wdata[7:0];
            if (reg_wr && reg_be[0] && reg_addr == 8'h0c) gate_ff <= reg_wdata[3];
            if (reg_wr && reg_be[0] && reg_addr == 8'h14) uen_ff[7:0] <= reg_wdata[7:0];
            if (reg_wr && reg_be[1] && reg_addr == 8'h14) uen_ff[15:8] <= reg_wdata[15:8];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    sequence s_evt;
        !cfg_ff[0] && gate_ff && (|(usb_evt & uen_ff));
    endsequence
    sequence s_hold;
        (gate_ff && old) [*2];
    endsequence
    property p_rst; $rose(nrst) |-> irq_pin && reg_rdata == 16'h0000; endproperty
    a_rst: assert property (p_rst) else $error("pin or read data wrong after reset");
    property p_cfg_rd; reg_rd && !reg_wr && reg_addr == 8'h10 |=> reg_rdata == {8'h00, cfg_ff}; endproperty
    a_cfg_rd: assert property (p_cfg_rd) else $error("config read back wrong");
    property p_unmapped; reg_rd && reg_addr == 8'h20 |=> reg_rdata == 16'h0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_evt_pin; s_evt ##1 s_hold |=> act; endproperty
    a_evt_pin: assert property (p_evt_pin) else $error("enabled event did not assert pin");
    property p_gate_mask; (!gate_ff && old) [*5] ##0 !act |=> !act; endproperty
    a_gate_mask: assert property (p_gate_mask) else $error("pin asserted with gate clear");
    property p_gate_hold; !cfg_ff[0] && old && $fell(gate_ff) && act |-> act ##1 act; endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("gate clear released pin");
    property p_level_stand; !cfg_ff[0] && old && $fell(act) |-> $past(clr_wr, 3); endproperty
    a_level_stand: assert property (p_level_stand) else $error("level pin released unasked");
    property p_pulse_len; cfg_ff[0] && old && $rose(act) |-> act ##1 act ##1 !act; endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("pulse not two cycles");
endmodule
bind upio_irq_ctrl upio_irq_checker #(.PCW(PCW)) chk (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .usb_evt(usb_evt), .dma_evt(dma_evt), .ctrl_ack(ctrl_ack), .ctrl_nak(ctrl_nak),
    .in_ack(in_ack), .in_nak(in_nak), .out_ack(out_ack), .out_nak(out_nak), .irq_pin(irq_pin)
);

// ===== sim/upio_mcu_model.sv
// microcontroller interrupt input: counts moves of the pin to its active level
`timescale 1ns/1ps
module upio_mcu_model (
    input  wire       ref_clk,
    input  wire       nrst,
    input  wire       irq_pin,
    input  wire       pol,
    output reg  [7:0] hits_ff
);
    reg last_ff;
    // one interrupt taken per entry into the active level, as an edge input would
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            hits_ff <= 8'h00;
            last_ff <= 1'b0;
        end else begin
            last_ff <= (irq_pin == pol);
            if ((irq_pin == pol) && !last_ff) hits_ff <= hits_ff + 8'h01;
        end
    end
endmodule

// ===== sim/tb_usb_peripheral_interrupt_output.sv
// register-level tests of the interrupt output block
`timescale 1ns/1ps
module tb_usb_peripheral_interrupt_output;
    reg         ref_clk = 1'b0;
    reg         nrst = 1'b0;
    reg  [7:0]  reg_addr = 8'h00;
    reg  [15:0] reg_wdata = 16'h0000;
    reg  [1:0]  reg_be = 2'h0;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    reg  [15:0] usb_evt = 16'h0000;
    reg  [15:0] dma_evt = 16'h0000;
    reg  [5:0]  pipe = 6'h00;
    reg         pol = 1'b0;
    wire [15:0] reg_rdata;
    wire        irq_pin;
    wire [7:0]  hits;
    integer     mismatches = 0;
    integer     tests_run = 0;
    integer     i;
    integer     k;
    reg  [7:0]  h0;
    reg  [1:0]  c;
    reg  [1:0]  n;
    reg  [1:0]  o;
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) fail(nm, ex, got); end
    always #25 ref_clk = ~ref_clk;
    upio_irq_ctrl dut (
        .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .usb_evt(usb_evt), .dma_evt(dma_evt), .ctrl_ack(pipe[5]), .ctrl_nak(pipe[4]),
        .in_ack(pipe[3]), .in_nak(pipe[2]), .out_ack(pipe[1]), .out_nak(pipe[0]),
        .irq_pin(irq_pin)
    );
    upio_mcu_model mcu (.ref_clk(ref_clk), .nrst(nrst), .irq_pin(irq_pin), .pol(pol), .hits_ff(hits));
    // does the select code let an ack (k=0) or nak (k=1) through
    function f(input [1:0] s, input integer kk);
        f = (s == 2'h0) || (s == 2'h1 && kk == 0) || (s == 2'h2 && kk == 1);
    endfunction
    task fail(input [8*8-1:0] nm, input [15:0] ex, input [15:0] got);
        mismatches++;
        $display("[FAIL] %0s expected %h seen %h", nm, ex, got);
    endtask
    task wr(input [7:0] a, input [15:0] d, input [1:0] be);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_be <= be;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input [7:0] a, input [15:0] ex);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        `CHK("rdata", ex, reg_rdata)
    endtask
    task ev(input [15:0] u, input [15:0] d, input [5:0] p);
        @(posedge ref_clk);
        usb_evt <= u;
        dma_evt <= d;
        pipe <= p;
        @(posedge ref_clk);
        usb_evt <= 16'h0000;
        dma_evt <= 16'h0000;
        pipe <= 6'h00;
    endtask
    // let n edges land, then look at the settled pin
    task pin(input integer cyc, input ex);
        repeat (cyc) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK("irq_pin", ex, irq_pin)
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // watchdog well beyond the fewer than two hundred cycles the sequence needs
    initial begin
        repeat (4000) @(posedge ref_clk);
        mismatches++;
        stop_test;
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        pin(0, 1'b1);
        rd(8'h10, 16'h0000);
        rd(8'h0c, 16'h0000);
        rd(8'h20, 16'h0000);
        wr(8'h10, 16'h00c0, 2'h2);
        rd(8'h10, 16'h0000);
        wr(8'h14, 16'h0020, 2'h3);
        wr(8'h0c, 16'h0008, 2'h3);
        ev(16'h0020, 16'h0000, 6'h00);
        pin(3, 1'b0);
        ev(16'h0040, 16'h0000, 6'h00);
        rd(8'h18, 16'h0060);
        wr(8'h18, 16'h0020, 2'h1);
        pin(2, 1'b0);
        wr(8'h18, 16'h0020, 2'h3);
        pin(2, 1'b1);
        wr(8'h18, 16'h0040, 2'h3);
        wr(8'h0c, 16'h0000, 2'h3);
        ev(16'h0020, 16'h0000, 6'h00);
        pin(3, 1'b1);
        rd(8'h18, 16'h0020);
        wr(8'h0c, 16'h0008, 2'h3);
        pin(3, 1'b0);
        wr(8'h0c, 16'h0000, 2'h3);
        pin(3, 1'b0);
        wr(8'h18, 16'h0020, 2'h3);
        pin(2, 1'b1);
        wr(8'h0c, 16'h0008, 2'h3);
        wr(8'h54, 16'h0001, 2'h3);
        ev(16'h0000, 16'h0001, 6'h00);
        pin(3, 1'b0);
        rd(8'h50, 16'h0001);
        wr(8'h50, 16'h0001, 2'h3);
        pin(2, 1'b1);
        wr(8'h0c, 16'hf0f0, 2'h2);
        rd(8'h0c, 16'hf008);
        pol <= 1'b1;
        wr(8'h10, 16'h0003, 2'h1);
        pin(2, 1'b0);
        h0 = hits;
        ev(16'h0020, 16'h0000, 6'h00);
        pin(2, 1'b1);
        pin(1, 1'b1);
        pin(1, 1'b0);
        ev(16'h0000, 16'h0001, 6'h00);
        pin(6, 1'b0);
        `CHK("pulses", h0 + 8'h01, hits)
        wr(8'h18, 16'h0020, 2'h3);
        wr(8'h50, 16'h0001, 2'h3);
        pol <= 1'b0;
        // each pipe field gets a different code so a swapped field shows up
        for (i = 0; i < 4; i++) begin
            for (k = 0; k < 2; k++) begin
                c = i[1:0];
                n = i[1:0] + 2'h1;
                o = i[1:0] + 2'h2;
                wr(8'h10, {8'h00, c, n, o, 2'h0}, 2'h1);
                ev(16'h0000, 16'h0000, (k == 1) ? 6'h15 : 6'h2a);
                rd(8'h18, {13'h0000, f(o, k), f(n, k), f(c, k)});
                wr(8'h18, 16'h0007, 2'h3);
            end
        end
        stop_test;
    end
endmodule
